// File: pkg/lcell_pkg.sv
package lcell_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_LUT_F = 5'h00;
    localparam logic [4:0] ADDR_LUT_G = 5'h04;
    localparam logic [4:0] ADDR_LUT_H = 5'h08;
    localparam logic [4:0] ADDR_CTRL = 5'h0C;
    localparam logic [4:0] ADDR_STATUS = 5'h10;
    localparam int ADDR_W = 5;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int LUT4_BITS = 16;
    localparam int LUT3_BITS = 8;
    localparam int GCLK_IDX_W = 2;
    localparam logic [15:0] LUT_F_RST = 16'h0000;
    localparam logic [15:0] LUT_G_RST = 16'h0000;
    localparam logic [7:0] LUT_H_RST = 8'h00;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Reserved control bits read zero
    localparam logic [31:0] CTRL_WMASK = 32'h801F_FFFF;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Storage element data sources
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_F = 2'h0;
    localparam logic [1:0] SRC_G = 2'h1;
    localparam logic [1:0] SRC_H = 2'h2;
    localparam logic [1:0] SRC_DIRECT = 2'h3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic lock;
        logic [9:0] rsvd;
        logic [1:0] g_gclk_idx;
        logic g_gclk_en;
        logic [1:0] f_gclk_idx;
        logic f_gclk_en;
        logic sr_use;
        logic ec_use;
        logic y_sr_set;
        logic x_sr_set;
        logic clk_inv;
        logic y_latch;
        logic x_latch;
        logic [1:0] yq_src;
        logic [1:0] xq_src;
        logic y_sel;
        logic x_sel;
        logic h2_ext;
        logic h0_ext;
    } lcell_ctrl_t;

    // Thirteen cell inputs from the interconnect
    typedef struct packed {
        logic [3:0] f_in;
        logic [3:0] g_in;
        logic combiner_external_input;
        logic direct_data;
        logic set_reset;
        logic clock_enable;
        logic cell_clock;
    } lcell_in_t;

    // Four cell outputs to the interconnect
    typedef struct packed {
        logic x;
        logic y;
        logic xq;
        logic yq;
    } lcell_out_t;

endpackage

// File: hw/lcell_top.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Operation
// - Two independent four-input look-up tables each realise any function of their inputs.
// - A three-input combining table takes F and G outputs or outside signals on two inputs.
// - Cascading F and G into the combining table gives some nine-variable functions.
// - Two storage elements can register generator outputs or be used on their own.
// - Each storage element is an edge flip-flop or, as an option, a level latch.
// - The direct data input can feed either storage element, bypassing the tables.
// - The combiner external input can reach the other storage element through H.
// - Two further outputs, X and Y, carry generator results apart from the storage elements, registered on aclk.
// - The cell boundary is thirteen inputs and four outputs to the interconnect.
// - Configuration memory fixes all tables and selections once configuration completes.
// - Global clock lines can be selected as inputs of the F and G tables.
// - Every table is a memory look-up so its delay is the same for any function.
// - X selects F or H, and Y selects G or H.
// - With three separate functions one must leave through a storage element.
module lcell_top #(
    parameter int GCLK_N = 4
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Sync reset, active low
    input wire logic ce, // Clock enable, low freezes all
    input wire logic [GCLK_N-1:0] gclk, // Global clock lines, sampled
    input wire lcell_pkg::lcell_in_t cell_in, // Routed cell inputs
    output lcell_pkg::lcell_out_t cell_out, // Routed cell outputs
    input wire logic [4:0] s_axi_awaddr, // AW address
    input wire logic [2:0] s_axi_awprot, // Unused
    input wire logic s_axi_awvalid, // AW valid
    output logic s_axi_awready, // AW ready
    input wire logic [31:0] s_axi_wdata, // W data
    input wire logic [3:0] s_axi_wstrb, // W strobes
    input wire logic s_axi_wvalid, // W valid
    output logic s_axi_wready, // W ready
    output logic [1:0] s_axi_bresp, // B response
    output logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic [4:0] s_axi_araddr, // AR address
    input wire logic [2:0] s_axi_arprot, // Unused
    input wire logic s_axi_arvalid, // AR valid
    output logic s_axi_arready, // AR ready
    output logic [31:0] s_axi_rdata, // R data
    output logic [1:0] s_axi_rresp, // R response
    output logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready // R ready
);

    // ------------------------------------------------------------
    // Configuration memory
    // ------------------------------------------------------------
    logic [lcell_pkg::LUT4_BITS-1:0] lut_f_reg;
    logic [lcell_pkg::LUT4_BITS-1:0] lut_g_reg;
    logic [lcell_pkg::LUT3_BITS-1:0] lut_h_reg;
    logic [31:0] ctrl_reg;
    lcell_pkg::lcell_ctrl_t cfg;

    assign cfg = lcell_pkg::lcell_ctrl_t'(ctrl_reg);

    // ------------------------------------------------------------
    // Write channel state
    // ------------------------------------------------------------
    logic aw_full_reg;
    logic [4:0] aw_addr_reg;
    logic w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic do_write;
    logic wr_hit;
    logic wr_cfg;

    // ------------------------------------------------------------
    // Read channel state
    // ------------------------------------------------------------
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rd_word;
    logic rd_hit;

    // ------------------------------------------------------------
    // Cell datapath
    // ------------------------------------------------------------
    logic [3:0] f_idx;
    logic [3:0] g_idx;
    logic [2:0] h_idx;
    logic f_out;
    logic g_out;
    logic h_out;
    logic x_reg;
    logic y_reg;
    logic clk_prev_reg;
    logic clk_active;
    logic clk_edge;
    logic [1:0] q_reg;
    logic [1:0] q_src [2];
    logic [1:0] q_latch;
    logic [1:0] q_sr_set;
    logic [1:0] q_data;

    // ------------------------------------------------------------
    // Byte-lane merge
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_word[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    // AW and W are taken in either order; the write waits for both
    assign s_axi_awready = ce && !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = ce && !w_full_reg && !bvalid_reg;
    assign do_write = ce && aw_full_reg && w_full_reg && !bvalid_reg;

    always_comb begin
        wr_hit = 1'b1;
        wr_cfg = 1'b1;
        unique case (aw_addr_reg)
            lcell_pkg::ADDR_LUT_F, lcell_pkg::ADDR_LUT_G,
            lcell_pkg::ADDR_LUT_H, lcell_pkg::ADDR_CTRL: begin
                wr_cfg = 1'b1;
            end
            lcell_pkg::ADDR_STATUS: begin
                wr_cfg = 1'b0;
            end
            default: begin
                wr_hit = 1'b0;
                wr_cfg = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[4:2], 2'h0};
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    // Once locked, writes are refused until reset, the only way to reconfigure
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= lcell_pkg::RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                if (wr_cfg && !cfg.lock) begin
                    bresp_reg <= lcell_pkg::RESP_OKAY;
                end else begin
                    bresp_reg <= lcell_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lut_f_reg <= lcell_pkg::LUT_F_RST;
            lut_g_reg <= lcell_pkg::LUT_G_RST;
            lut_h_reg <= lcell_pkg::LUT_H_RST;
            ctrl_reg <= lcell_pkg::CTRL_RST;
        end else if (ce && do_write && wr_hit && !cfg.lock) begin
            unique case (aw_addr_reg)
                lcell_pkg::ADDR_LUT_F: begin
                    lut_f_reg <= lcell_pkg::LUT4_BITS'(
                        merge_strb({16'h0000, lut_f_reg}, w_data_reg, w_strb_reg));
                end
                lcell_pkg::ADDR_LUT_G: begin
                    lut_g_reg <= lcell_pkg::LUT4_BITS'(
                        merge_strb({16'h0000, lut_g_reg}, w_data_reg, w_strb_reg));
                end
                lcell_pkg::ADDR_LUT_H: begin
                    lut_h_reg <= lcell_pkg::LUT3_BITS'(
                        merge_strb({24'h00_0000, lut_h_reg}, w_data_reg, w_strb_reg));
                end
                lcell_pkg::ADDR_CTRL: begin
                    ctrl_reg <= merge_strb(ctrl_reg, w_data_reg, w_strb_reg)
                        & lcell_pkg::CTRL_WMASK;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    assign s_axi_arready = ce && !rvalid_reg;

    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        unique case ({s_axi_araddr[4:2], 2'h0})
            lcell_pkg::ADDR_LUT_F: rd_word = {16'h0000, lut_f_reg};
            lcell_pkg::ADDR_LUT_G: rd_word = {16'h0000, lut_g_reg};
            lcell_pkg::ADDR_LUT_H: rd_word = {24'h00_0000, lut_h_reg};
            lcell_pkg::ADDR_CTRL: rd_word = ctrl_reg;
            lcell_pkg::ADDR_STATUS: rd_word = {15'h0000, cell_in, cell_out};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= lcell_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? lcell_pkg::RESP_OKAY : lcell_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ------------------------------------------------------------
    // Function generators
    // ------------------------------------------------------------
    // The fourth input of F and G may come from a global clock line.
    always_comb begin
        f_idx = cell_in.f_in;
        g_idx = cell_in.g_in;
        if (cfg.f_gclk_en) begin
            f_idx[3] = gclk[cfg.f_gclk_idx];
        end
        if (cfg.g_gclk_en) begin
            g_idx[3] = gclk[cfg.g_gclk_idx];
        end
    end

    // Plain table reads: the path is one mux whatever the function.
    assign f_out = lut_f_reg[f_idx];
    assign g_out = lut_g_reg[g_idx];

    // H index is {F or direct data, combiner input, G or set/reset}
    assign h_idx = {cfg.h2_ext ? cell_in.direct_data : f_out,
                    cell_in.combiner_external_input,
                    cfg.h0_ext ? cell_in.set_reset : g_out};
    assign h_out = lut_h_reg[h_idx];

    // ------------------------------------------------------------
    // X and Y function outputs
    // ------------------------------------------------------------
    // Registered to be glitch-free, at one cycle of latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            x_reg <= 1'b0;
            y_reg <= 1'b0;
        end else if (ce) begin
            x_reg <= cfg.x_sel ? h_out : f_out;
            y_reg <= cfg.y_sel ? h_out : g_out;
        end
    end

    // ------------------------------------------------------------
    // Storage elements
    // ------------------------------------------------------------
    // The cell clock is sampled data: its edge is seen against the last sample
    assign clk_active = cell_in.cell_clock ^ cfg.clk_inv;
    assign clk_edge = clk_active && !clk_prev_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_prev_reg <= 1'b0;
        end else if (ce) begin
            clk_prev_reg <= clk_active;
        end
    end

    assign q_src[0] = cfg.xq_src;
    assign q_src[1] = cfg.yq_src;
    assign q_latch = {cfg.y_latch, cfg.x_latch};
    assign q_sr_set = {cfg.y_sr_set, cfg.x_sr_set};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_store
            logic load;
            logic en;

            // Any source per element; third function leaves via here
            always_comb begin
                unique case (q_src[i])
                    lcell_pkg::SRC_F: q_data[i] = f_out;
                    lcell_pkg::SRC_G: q_data[i] = g_out;
                    lcell_pkg::SRC_H: q_data[i] = h_out;
                    lcell_pkg::SRC_DIRECT: q_data[i] = cell_in.direct_data;
                endcase
            end

            assign en = !cfg.ec_use || cell_in.clock_enable;
            assign load = q_latch[i] ? clk_active : clk_edge;

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    q_reg[i] <= 1'b0;
                end else if (ce) begin
                    if (cfg.sr_use && cell_in.set_reset) begin
                        q_reg[i] <= q_sr_set[i];
                    end else if (load && en) begin
                        q_reg[i] <= q_data[i];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Cell outputs
    // ------------------------------------------------------------
    assign cell_out = '{x: x_reg, y: y_reg, xq: q_reg[0], yq: q_reg[1]};

endmodule

// File: bench/lcell_top_asserts.sv
`timescale 1ns/10ps
module lcell_top_asserts (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Reset, active low
    input wire logic ce, // Clock enable
    input wire lcell_pkg::lcell_out_t cell_out, // Cell outputs
    input wire logic [4:0] s_axi_awaddr, // AW address
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic [1:0] s_axi_bresp, // B response
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic [4:0] s_axi_araddr, // AR address
    input wire logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata, // R data
    input wire logic [1:0] s_axi_rresp, // R response
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready // R ready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write open while busy");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read open while busy");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data not held");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    read_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:2] > 3'h4
        |=> s_axi_rresp == lcell_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    status_write_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && ce && s_axi_awaddr == lcell_pkg::ADDR_STATUS
        |-> ##2 (s_axi_bvalid && s_axi_bresp == lcell_pkg::RESP_SLVERR))
        else $error("status write not refused");
    ctrl_reserved_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == lcell_pkg::ADDR_CTRL
        |=> (s_axi_rdata & ~lcell_pkg::CTRL_WMASK) == 32'h0)
        else $error("reserved ctrl bits set");
    cell_clear_a: assert property (disable iff (1'b0) !aresetn && ce |=> cell_out == 4'h0)
        else $error("cell outputs not reset");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($rose(cell_out.xq));
endmodule

// File: bench/lcell_route_model.sv
`timescale 1ns/10ps
// Routed nets: requested levels appear one aclk later
module lcell_route_model #(
    parameter int GCLK_N = 4
) (
    input wire logic aclk, // System clock
    input wire lcell_pkg::lcell_in_t net_req, // Requested nets
    input wire logic [GCLK_N-1:0] gclk_req, // Requested global lines
    output lcell_pkg::lcell_in_t cell_in, // Nets into the cell
    output logic [GCLK_N-1:0] gclk // Global clock lines
);
    always_ff @(posedge aclk) begin
        cell_in <= net_req;
        gclk <= gclk_req;
    end
endmodule

// File: bench/configurable_logic_cell_test.sv
`timescale 1ns/10ps
module configurable_logic_cell_test;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic aclk, aresetn, ce;
    logic [3:0] gclk_req, gclk;
    lcell_pkg::lcell_in_t net_req, cell_in;
    lcell_pkg::lcell_out_t cell_out;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] rd;
    lcell_pkg::lcell_ctrl_t cfg;
    int n_mismatch = 0;
    int cmp_count = 0;

    lcell_route_model #(.GCLK_N(4)) i_route (.aclk, .net_req, .gclk_req, .cell_in, .gclk);
    lcell_top #(.GCLK_N(4)) i_dut (.aclk, .aresetn, .ce, .gclk, .cell_in, .cell_out,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Route delay plus one cell cycle, then one spare edge
    task automatic apply(input logic [3:0] f, input logic [3:0] g, input logic h1,
                         input logic d, input logic clk);
        @(posedge aclk);
        net_req <= '{f_in: f, g_in: g, combiner_external_input: h1, direct_data: d,
                     set_reset: 1'b0, clock_enable: 1'b1, cell_clock: clk};
        repeat (3) @(posedge aclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_reg(lcell_pkg::ADDR_CTRL, rd, resp);
        check("ctrl reset", rd, lcell_pkg::CTRL_RST);
        rd_reg(5'h14, rd, resp);
        check("unmapped resp", 32'(resp), 32'(lcell_pkg::RESP_SLVERR));
        check("unmapped data", rd, 32'h0);
        wr_reg(lcell_pkg::ADDR_STATUS, 32'hFFFF_FFFF, resp);
        check("status write", 32'(resp), 32'(lcell_pkg::RESP_SLVERR));
        wr_reg(lcell_pkg::ADDR_CTRL, 32'h7FFF_FFFF, resp);
        rd_reg(lcell_pkg::ADDR_CTRL, rd, resp);
        check("ctrl mask", rd, 32'h001F_FFFF);
        wr_reg(lcell_pkg::ADDR_LUT_H, 32'hFFFF_FFFF, resp);
        rd_reg(lcell_pkg::ADDR_LUT_H, rd, resp);
        check("lut h width", rd, 32'h0000_00FF);
        $display("register test done");
    endtask

    task automatic t_logic();
        logic [8:0] v;
        wr_reg(lcell_pkg::ADDR_LUT_F, 32'h0000_6996, resp);
        wr_reg(lcell_pkg::ADDR_LUT_G, 32'h0000_6996, resp);
        wr_reg(lcell_pkg::ADDR_LUT_H, 32'h0000_0096, resp);
        for (int s = 0; s < 2; s++) begin
            cfg = '0;
            cfg.x_sel = s[0];
            cfg.y_sel = !s[0];
            wr_reg(lcell_pkg::ADDR_CTRL, cfg, resp);
            for (int k = 0; k < 6; k++) begin
                v = 9'(k * 83 + 1);
                apply(v[3:0], v[7:4], v[8], 1'b0, 1'b0);
                check("x out", 32'(cell_out.x), 32'(s ? ^v : ^v[3:0]));
                check("y out", 32'(cell_out.y), 32'(s ? ^v[7:4] : ^v));
            end
        end
        $display("logic test done");
    endtask

    task automatic t_gclk();
        logic [3:0] pat;
        wr_reg(lcell_pkg::ADDR_LUT_F, 32'h0000_FF00, resp);
        wr_reg(lcell_pkg::ADDR_LUT_G, 32'h0000_FF00, resp);
        cfg = '0;
        cfg.f_gclk_en = 1'b1;
        cfg.f_gclk_idx = 2'h2;
        cfg.g_gclk_en = 1'b1;
        cfg.g_gclk_idx = 2'h1;
        wr_reg(lcell_pkg::ADDR_CTRL, cfg, resp);
        for (int k = 0; k < 4; k++) begin
            pat = 4'(k * 3 + 1);
            @(posedge aclk);
            gclk_req <= pat;
            apply(4'h8, 4'h8, 1'b0, 1'b0, 1'b0);
            check("gclk x", 32'(cell_out.x), 32'(pat[2]));
            check("gclk y", 32'(cell_out.y), 32'(pat[1]));
        end
        $display("global line test done");
    endtask

    // Steps are {cell_clock, direct_data, combiner input, xq, yq}
    task automatic t_store();
        logic [4:0] steps [8] = '{5'h08, 5'h1A, 5'h16, 5'h06, 5'h15, 5'h1A, 5'h15, 5'h09};
        wr_reg(lcell_pkg::ADDR_LUT_H, 32'h0000_00CC, resp);
        cfg = '0;
        cfg.xq_src = lcell_pkg::SRC_DIRECT;
        cfg.yq_src = lcell_pkg::SRC_H;
        wr_reg(lcell_pkg::ADDR_CTRL, cfg, resp);
        for (int i = 0; i < 8; i++) begin
            if (i == 5) begin
                cfg.x_latch = 1'b1;
                cfg.y_latch = 1'b1;
                wr_reg(lcell_pkg::ADDR_CTRL, cfg, resp);
            end
            apply(4'h3, 4'h5, steps[i][2], steps[i][3], steps[i][4]);
            check("xq", 32'(cell_out.xq), 32'(steps[i][1]));
            check("yq", 32'(cell_out.yq), 32'(steps[i][0]));
        end
        rd_reg(lcell_pkg::ADDR_STATUS, rd, resp);
        check("status", rd, 32'h0000_6AA1);
        $display("storage test done");
    endtask

    task automatic t_lock();
        cfg = '0;
        cfg.lock = 1'b1;
        wr_reg(lcell_pkg::ADDR_CTRL, cfg, resp);
        check("lock write", 32'(resp), 32'(lcell_pkg::RESP_OKAY));
        wr_reg(lcell_pkg::ADDR_LUT_F, 32'h0000_1234, resp);
        check("locked resp", 32'(resp), 32'(lcell_pkg::RESP_SLVERR));
        rd_reg(lcell_pkg::ADDR_LUT_F, rd, resp);
        check("locked lut", rd, 32'h0000_FF00);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(lcell_pkg::ADDR_CTRL, rd, resp);
        check("unlock", rd, 32'h0);
        $display("lock test done");
    endtask

    // ------------------------------------------------------------
    // Main
    // ------------------------------------------------------------
    initial begin
        aresetn = 1'b0;
        ce = 1'b1;
        gclk_req = 4'h0;
        net_req = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_logic();
        t_gclk();
        t_store();
        t_lock();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        $display("watchdog expired");
        end_sim();
    end
endmodule

bind lcell_top lcell_top_asserts i_chk (.aclk, .aresetn, .ce, .cell_out, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
